/* File: common/ltmc_map.svh */
`ifndef LTMC_MAP_SVH
`define LTMC_MAP_SVH
// Transceiver mode field encodings
`define LTMC_MODE_OFF    2'h0
`define LTMC_MODE_WAKE   2'h1
`define LTMC_MODE_RXONLY 2'h2
`define LTMC_MODE_NORMAL 2'h3
// Chip operating modes
`define LTMC_CHIP_NORMAL  3'h0
`define LTMC_CHIP_STOP    3'h1
`define LTMC_CHIP_SLEEP   3'h2
`define LTMC_CHIP_RESTART 3'h3
`define LTMC_CHIP_FAILSAFE 3'h4
// Timing at 100 MHz
`define LTMC_CLK_NS        10
`define LTMC_EN_TIME_NS    10000
`define LTMC_EN_CYCLES     ((`LTMC_EN_TIME_NS + `LTMC_CLK_NS - 1) / `LTMC_CLK_NS)
`define LTMC_FILT_CYCLES   4
`define LTMC_TXTO_CYCLES   200000
`define LTMC_WAKE_CYCLES   3000
`endif

/* File: common/ltmc_pkg.sv */
package ltmc_pkg;
  typedef enum logic [1:0] {
    LTMC_ST_OFF    = 2'b00,
    LTMC_ST_ENABLE = 2'b01,
    LTMC_ST_ACTIVE = 2'b10,
    LTMC_ST_RXONLY = 2'b11
  } ltmc_state_t;
endpackage : ltmc_pkg

/* File: hw/ltmc_lane.sv */
`include "ltmc_map.svh"
module ltmc_lane
  import ltmc_pkg::*;
#(
  parameter int EN_CYCLES   = `LTMC_EN_CYCLES,
  parameter int FILT_CYCLES = `LTMC_FILT_CYCLES,
  parameter int TXTO_CYCLES = `LTMC_TXTO_CYCLES,
  parameter int WAKE_CYCLES = `LTMC_WAKE_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [1:0] i_mode_field,
  input  wire logic [2:0] i_chip_mode,
  input  wire logic       i_tx,
  input  wire logic       i_bus,
  input  wire logic       i_fault_clear,
  output logic            o_rx,
  output logic            o_drive_dominant,
  output logic            o_fault,
  output logic            o_wake,
  output logic [1:0]      o_mode
);
  // Counters share one width, so size it for the largest count in use
  localparam int CNT_A  = (TXTO_CYCLES > EN_CYCLES) ? TXTO_CYCLES : EN_CYCLES;
  localparam int CNT_B  = (WAKE_CYCLES > FILT_CYCLES) ? WAKE_CYCLES : FILT_CYCLES;
  localparam int CNT_MX = (CNT_A > CNT_B) ? CNT_A : CNT_B;
  localparam int CW     = $clog2(CNT_MX + 2);
  ltmc_state_t state_reg;
  logic [1:0]    mode_reg;
  logic [CW-1:0] en_cnt_reg;
  logic [CW-1:0] filt_cnt_reg;
  logic [CW-1:0] to_cnt_reg;
  logic [CW-1:0] wk_cnt_reg;
  logic          bus_filt_reg;
  logic          armed_reg;
  logic          woken_reg;
  logic          fault_reg;
  logic          rx_reg;
  logic          drive_reg;
  logic          chip_ok;
  logic [1:0]    mode_next;
  logic          timeout;

  assign chip_ok = (i_chip_mode == `LTMC_CHIP_NORMAL) || (i_chip_mode == `LTMC_CHIP_STOP);

  // Normal and receive-only fall back to off outside normal/stop; chip failsafe forces wake for every field
  always_comb begin
    mode_next = i_mode_field;
    if (((i_mode_field == `LTMC_MODE_NORMAL) || (i_mode_field == `LTMC_MODE_RXONLY)) && !chip_ok)
      mode_next = `LTMC_MODE_OFF;
    if (i_chip_mode == `LTMC_CHIP_FAILSAFE)
      mode_next = `LTMC_MODE_WAKE;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) mode_reg <= `LTMC_MODE_OFF;
    else mode_reg <= mode_next;
  end

  // Receive noise filter: level must hold FILT_CYCLES before it is accepted
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bus_filt_reg <= 1'b1;
      filt_cnt_reg <= '0;
    end else if (i_bus == bus_filt_reg) begin
      filt_cnt_reg <= '0;
    end else if (filt_cnt_reg == CW'(FILT_CYCLES - 1)) begin
      bus_filt_reg <= i_bus;
      filt_cnt_reg <= '0;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 1'b1;
    end
  end

  // Enabling sequence: count, then wait for recessive before the first dominant
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg  <= LTMC_ST_OFF;
      en_cnt_reg <= '0;
    end else begin
      case (state_reg)
        LTMC_ST_OFF: begin
          en_cnt_reg <= '0;
          if (mode_reg == `LTMC_MODE_NORMAL) state_reg <= LTMC_ST_ENABLE;
          else if (mode_reg == `LTMC_MODE_RXONLY) state_reg <= LTMC_ST_RXONLY;
        end
        LTMC_ST_ENABLE: begin
          if (mode_reg != `LTMC_MODE_NORMAL) state_reg <= LTMC_ST_OFF;
          else if (en_cnt_reg >= CW'(EN_CYCLES - 1)) begin
            // A dominant held across the end of enabling is not sent
            if (i_tx) state_reg <= LTMC_ST_ACTIVE;
          end else en_cnt_reg <= en_cnt_reg + 1'b1;
        end
        LTMC_ST_ACTIVE: if (mode_reg != `LTMC_MODE_NORMAL) state_reg <= LTMC_ST_OFF;
        LTMC_ST_RXONLY: if (mode_reg != `LTMC_MODE_RXONLY) state_reg <= LTMC_ST_OFF;
        default: state_reg <= LTMC_ST_OFF;
      endcase
    end
  end

  // Transmit dominant time-out releases the driver temporarily
  always_ff @(posedge i_clk) begin
    if (i_reset) to_cnt_reg <= '0;
    else if (state_reg != LTMC_ST_ACTIVE || i_tx) to_cnt_reg <= '0;
    else if (!timeout) to_cnt_reg <= to_cnt_reg + 1'b1;
  end
  assign timeout = (to_cnt_reg >= CW'(TXTO_CYCLES));

  always_ff @(posedge i_clk) begin
    if (i_reset) fault_reg <= 1'b0;
    else if (timeout) fault_reg <= 1'b1;
    else if (i_fault_clear) fault_reg <= 1'b0;
  end

  // Driver: only active state, never off or receive-only
  always_ff @(posedge i_clk) begin
    if (i_reset) drive_reg <= 1'b0;
    // Mode gate drops the driver on the edge after the mode leaves normal, together with the state, not one later
    else drive_reg <= (state_reg == LTMC_ST_ACTIVE) && (mode_reg == `LTMC_MODE_NORMAL)
                      && !i_tx && !timeout;
  end

  // Wake detection: dominant longer than WAKE_CYCLES then release
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wk_cnt_reg <= '0;
      armed_reg  <= 1'b0;
      woken_reg  <= 1'b0;
    end else if (mode_next != `LTMC_MODE_WAKE) begin
      // Cleared together with the mode change, so off never shows a stale wake
      wk_cnt_reg <= '0;
      armed_reg  <= 1'b0;
      woken_reg  <= 1'b0;  // Leaving wake mode rearms
    end else if (!bus_filt_reg) begin
      if (wk_cnt_reg >= CW'(WAKE_CYCLES)) armed_reg <= 1'b1;
      else wk_cnt_reg <= wk_cnt_reg + 1'b1;
    end else begin
      wk_cnt_reg <= '0;
      armed_reg  <= 1'b0;
      if (armed_reg) woken_reg <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) rx_reg <= 1'b1;
    else if (mode_reg == `LTMC_MODE_WAKE) rx_reg <= !woken_reg;
    else if (state_reg == LTMC_ST_OFF) rx_reg <= 1'b1;
    else rx_reg <= bus_filt_reg;
  end

  assign o_rx             = rx_reg;
  assign o_drive_dominant = drive_reg;
  assign o_fault          = fault_reg;
  assign o_wake           = woken_reg;
  assign o_mode           = mode_reg;

  a_off_no_drive: assert property (@(posedge i_clk) disable iff (i_reset)
    (mode_reg == `LTMC_MODE_OFF) |=> !drive_reg) else $error("driver on in off");
  a_rxonly_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_reg == LTMC_ST_RXONLY) |=> !drive_reg) else $error("driver on in rx only");
  a_tx_follow: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_reg == LTMC_ST_ACTIVE && mode_reg == `LTMC_MODE_NORMAL && !timeout)
    |=> drive_reg == !$past(i_tx))
    else $error("bus not following tx");
  a_enable_gate: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_reg == LTMC_ST_ENABLE) |=> !drive_reg) else $error("drive before enable");
  a_off_no_wake: assert property (@(posedge i_clk) disable iff (i_reset)
    (mode_reg == `LTMC_MODE_OFF) |-> !woken_reg) else $error("wake in off");
  a_normal_legal: assert property (@(posedge i_clk) disable iff (i_reset)
    (mode_reg == `LTMC_MODE_NORMAL || mode_reg == `LTMC_MODE_RXONLY) |-> $past(chip_ok))
    else $error("normal outside chip mode");
  a_fault_set: assert property (@(posedge i_clk) disable iff (i_reset)
    timeout |=> fault_reg) else $error("fault not set");
  a_wake_rx_low: assert property (@(posedge i_clk) disable iff (i_reset)
    (woken_reg && mode_reg == `LTMC_MODE_WAKE) |=> !rx_reg) else $error("rx not low");
  a_rx_level: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_reg == LTMC_ST_ACTIVE && mode_reg == `LTMC_MODE_NORMAL) |=> rx_reg == $past(bus_filt_reg))
    else $error("rx mismatch");
  c_active: cover property (@(posedge i_clk) state_reg == LTMC_ST_ACTIVE ##1 drive_reg);
  c_wake: cover property (@(posedge i_clk) $rose(woken_reg));
  c_timeout: cover property (@(posedge i_clk) $rose(fault_reg));
endmodule : ltmc_lane

/* File: hw/ltmc_top.sv */
// Function
// - Both transceivers come out of reset in off mode and off may be chosen at any time except in chip failsafe, which forces wake mode.
// - In off mode the bus is never driven and wake activity is ignored.
// - Each transceiver follows its own mode field.
// - A request for normal mode is honoured while the chip is in normal mode.
// - Normal mode exists only in chip normal or stop mode.
// - Once enabled, transmit low drives dominant and high leaves recessive.
// - The receive output shows the filtered bus level while reception is on.
// - Short bus glitches are filtered before reaching the receive output.
// - A dominant begun during enabling is never sent; only one after recessive is.
// - Receive-only mode disables the driver while receiving.
// - Receive-only mode is allowed only in chip normal or stop mode.
// - Mode value 01 is wake capable; after a wake the field stays and receive is held low.
// - A transmit dominant time-out sets that transceiver's fault flag.
`include "ltmc_map.svh"
module ltmc_top
  import ltmc_pkg::*;
#(
  parameter int EN_CYCLES   = `LTMC_EN_CYCLES,
  parameter int FILT_CYCLES = `LTMC_FILT_CYCLES,
  parameter int TXTO_CYCLES = `LTMC_TXTO_CYCLES,
  parameter int WAKE_CYCLES = `LTMC_WAKE_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic [2:0] i_chip_mode,
  input  wire logic [1:0] i_first_transceiver_mode_field,
  input  wire logic [1:0] i_second_transceiver_mode_field,
  input  wire logic [1:0] i_lin_transmit_input,
  input  wire logic [1:0] i_lin_bus,
  input  wire logic [1:0] i_fault_clear,
  output logic      [1:0] o_lin_receive,
  output logic      [1:0] o_lin_bus_out,
  output logic      [1:0] o_lin_bus_oe,
  output logic            o_first_transceiver_fault_flag,
  output logic            o_second_transceiver_fault_flag,
  output logic      [1:0] o_bus_wake,
  output logic      [1:0] o_first_mode,
  output logic      [1:0] o_second_mode
);
  logic [1:0] tx_s1_reg;
  logic [1:0] tx_s2_reg;
  logic [1:0] bus_s1_reg;
  logic [1:0] bus_s2_reg;
  logic [1:0] drive;
  logic [1:0] fault;
  logic [3:0] modes;

  // Pins are asynchronous: two stages before any use
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_s1_reg  <= 2'h3;
      tx_s2_reg  <= 2'h3;
      bus_s1_reg <= 2'h3;
      bus_s2_reg <= 2'h3;
    end else begin
      tx_s1_reg  <= i_lin_transmit_input;
      tx_s2_reg  <= tx_s1_reg;
      bus_s1_reg <= i_lin_bus;
      bus_s2_reg <= bus_s1_reg;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_lane
    ltmc_lane #(
      .EN_CYCLES  (EN_CYCLES),
      .FILT_CYCLES(FILT_CYCLES),
      .TXTO_CYCLES(TXTO_CYCLES),
      .WAKE_CYCLES(WAKE_CYCLES)
    ) u_lane (
      .i_clk           (i_clk),
      .i_reset         (i_reset),
      .i_mode_field    (g == 0 ? i_first_transceiver_mode_field
                               : i_second_transceiver_mode_field),
      .i_chip_mode     (i_chip_mode),
      .i_tx            (tx_s2_reg[g]),
      .i_bus           (bus_s2_reg[g]),
      .i_fault_clear   (i_fault_clear[g]),
      .o_rx            (o_lin_receive[g]),
      .o_drive_dominant(drive[g]),
      .o_fault         (fault[g]),
      .o_wake          (o_bus_wake[g]),
      .o_mode          (modes[2*g +: 2])
    );
  end

  // Open drain: only dominant is driven, recessive is released
  assign o_lin_bus_out = 2'h0;
  assign o_lin_bus_oe  = drive;
  assign o_first_transceiver_fault_flag  = fault[0];
  assign o_second_transceiver_fault_flag = fault[1];
  assign o_first_mode  = modes[1:0];
  assign o_second_mode = modes[3:2];
endmodule : ltmc_top

/* File: bench/ltmc_far_node.sv */
module ltmc_far_node (
  input  wire logic [1:0] i_oe,
  input  wire logic [1:0] i_dominant,
  output logic      [1:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up holds recessive; any party pulling low wins, as on a real wire
  assign o_bus = ~(i_oe | i_dominant);
endmodule : ltmc_far_node

/* File: bench/lin_transceiver_mode_control_test.sv */
`include "ltmc_map.svh"
module lin_transceiver_mode_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EN = 30;
  logic       i_clk;
  logic       i_reset;
  logic [2:0] chip;
  logic [1:0] f0, f1, tx, dom, clr, bus, rx, oe, wake, m0, m1;
  logic       fl0, fl1;
  int         err_count;
  int         n_checks;

  ltmc_top #(.EN_CYCLES(EN), .FILT_CYCLES(4), .TXTO_CYCLES(50), .WAKE_CYCLES(20)) ltmc_top_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_chip_mode(chip),
    .i_first_transceiver_mode_field(f0), .i_second_transceiver_mode_field(f1),
    .i_lin_transmit_input(tx), .i_lin_bus(bus), .i_fault_clear(clr),
    .o_lin_receive(rx), .o_lin_bus_out(), .o_lin_bus_oe(oe),
    .o_first_transceiver_fault_flag(fl0), .o_second_transceiver_fault_flag(fl1),
    .o_bus_wake(wake), .o_first_mode(m0), .o_second_mode(m1)
  );

  ltmc_far_node ltmc_far_node_inst (.i_oe(oe), .i_dominant(dom), .o_bus(bus));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  task automatic chk(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test

  task automatic t_reset;
    chk("mode0", `LTMC_MODE_OFF, m0);
    chk("mode1", `LTMC_MODE_OFF, m1);
    chk("oe", 2'h0, oe);
    chk("faults", 2'h0, {fl1, fl0});
    chk("rx reset", 2'h3, rx);
    chk("wake reset", 2'h0, wake);
    $display("test reset done");
  endtask : t_reset

  task automatic t_off;
    dom <= 2'h3;
    cyc(30);
    chk("rx off", 2'h3, rx);
    dom <= 2'h0;
    cyc(12);
    chk("wake off", 2'h0, wake);
    chk("oe off", 2'h0, oe);
    $display("test off done");
  endtask : t_off

  task automatic t_normal;
    f0 <= `LTMC_MODE_NORMAL;
    cyc(3);
    chk("mode0 normal", `LTMC_MODE_NORMAL, m0);
    chk("mode1 stays", `LTMC_MODE_OFF, m1);
    tx <= 2'h2;
    cyc(40);
    chk("early dominant", 2'h0, oe);
    tx <= 2'h3;
    cyc(5);
    tx <= 2'h2;
    cyc(5);
    chk("oe dominant", 2'h1, oe);
    cyc(10);
    chk("rx dominant", 2'h2, rx);
    tx <= 2'h3;
    cyc(5);
    chk("oe recessive", 2'h0, oe);
    $display("test normal done");
  endtask : t_normal

  task automatic t_chip;
    chip <= `LTMC_CHIP_SLEEP;
    cyc(4);
    chk("normal in sleep", `LTMC_MODE_OFF, m0);
    f0 <= `LTMC_MODE_OFF;
    chip <= `LTMC_CHIP_STOP;
    f1 <= `LTMC_MODE_RXONLY;
    cyc(4);
    chk("rxonly stop", `LTMC_MODE_RXONLY, m1);
    tx <= 2'h0;
    dom <= 2'h2;
    cyc(12);
    chk("rxonly oe", 2'h0, oe);
    chk("rxonly rx", 2'h1, rx);
    dom <= 2'h0;
    cyc(12);
    dom <= 2'h2;
    cyc(2);
    dom <= 2'h0;
    // Watch every cycle: an unfiltered pulse would show only briefly
    repeat (12) begin
      cyc(1);
      chk("glitch", 2'h3, rx);
    end
    chip <= `LTMC_CHIP_SLEEP;
    cyc(4);
    chk("rxonly sleep", `LTMC_MODE_OFF, m1);
    tx <= 2'h3;
    chip <= `LTMC_CHIP_NORMAL;
    f1 <= `LTMC_MODE_OFF;
    $display("test chip done");
  endtask : t_chip

  task automatic t_fault;
    f0 <= `LTMC_MODE_NORMAL;
    cyc(EN + 10);
    tx <= 2'h2;
    cyc(70);
    chk("fault set", 2'h1, {fl1, fl0});
    chk("oe after timeout", 2'h0, oe);
    // Clear while the time-out still stands: the set must win
    tx <= 2'h3;
    clr <= 2'h1;
    cyc(2);
    chk("fault held", 2'h1, {fl1, fl0});
    cyc(3);
    clr <= 2'h0;
    cyc(2);
    chk("fault clear", 2'h0, {fl1, fl0});
    $display("test fault done");
  endtask : t_fault

  task automatic t_wake;
    f1 <= `LTMC_MODE_WAKE;
    cyc(4);
    dom <= 2'h2;
    cyc(30);
    chk("no wake yet", 2'h0, wake);
    dom <= 2'h0;
    cyc(12);
    chk("wake", 2'h2, wake);
    chk("wake mode", `LTMC_MODE_WAKE, m1);
    chk("wake rx", 2'h1, rx);
    chip <= `LTMC_CHIP_FAILSAFE;
    cyc(3);
    chk("failsafe mode0", `LTMC_MODE_WAKE, m0);
    chk("failsafe mode1", `LTMC_MODE_WAKE, m1);
    chk("failsafe oe", 2'h0, oe);
    chk("failsafe wake", 2'h2, wake);
    $display("test wake done");
  endtask : t_wake

  initial begin
    err_count = 0;
    n_checks = 0;
    i_reset = 1'b1;
    chip = `LTMC_CHIP_NORMAL;
    f0 = `LTMC_MODE_OFF;
    f1 = `LTMC_MODE_OFF;
    tx = 2'h3;
    dom = 2'h0;
    clr = 2'h0;
    cyc(8);
    i_reset <= 1'b0;
    cyc(2);
    t_reset;
    t_off;
    t_normal;
    t_chip;
    t_fault;
    t_wake;
    end_of_test;
  end

  // Whole run needs well under 1000 cycles
  initial begin
    cyc(20000);
    err_count++;
    end_of_test;
  end
endmodule : lin_transceiver_mode_control_test
